// ---- msi_pkg.sv ----
// Constants, types and timing counts shared by the motor safety interlock.
// Assumes a single 250 MHz clock and a synchronous active-high reset.
package msi_pkg;

   localparam int unsigned CLK_HZ         = 250_000_000;
   // Battery current in milliamps; analog input in millivolts.
   localparam int unsigned CUR_LIMIT_MA   = 1000;
   localparam int unsigned FAULT_TIME_MS  = 500;
   localparam int unsigned FAULT_CYCLES   = CLK_HZ / 1000 * FAULT_TIME_MS;
   localparam int unsigned ANA_MIN_MV     = 250;
   localparam int unsigned ANA_MAX_MV     = 4750;
   localparam int unsigned BLINK_PERIOD_MS = 2000;
   localparam int unsigned BLINK_HALF_CYC = CLK_HZ / 1000 * (BLINK_PERIOD_MS / 2);
   localparam int unsigned SELFCHK_CYCLES = 16;

   // Interrupt status and mask bit positions.
   localparam int unsigned EV_FAULT     = 0;
   localparam int unsigned EV_TORQUE_OFF = 1;
   localparam int unsigned EV_CHK_FAIL  = 2;
   localparam int unsigned EV_SRC_CHG   = 3;
   localparam int unsigned EV_W         = 4;

   // Register offsets.
   localparam logic [3:0] REG_CTRL   = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h1;
   localparam logic [3:0] REG_IRQ_ST = 4'h2;
   localparam logic [3:0] REG_IRQ_MK = 4'h3;

   // Control register field positions and reset value.
   localparam int unsigned CTRL_ANA_EN   = 0;
   localparam int unsigned CTRL_ANA_SLOT = 1;
   localparam int unsigned CTRL_RUN_REQ  = 2;
   localparam int unsigned CTRL_CONTACT  = 3;
   localparam int unsigned CTRL_BRAKE1   = 4;
   localparam int unsigned CTRL_BRAKE2   = 5;
   localparam logic [7:0]  CTRL_RESET    = 8'h00;

   typedef enum logic [1:0] {
      MSI_SRC_NONE   = 2'b00,
      MSI_SRC_SERIAL = 2'b01,
      MSI_SRC_PULSE  = 2'b10,
      MSI_SRC_ANALOG = 2'b11
   } msi_src_t;

   typedef enum logic [1:0] {
      MSI_TO_OFF   = 2'b00,
      MSI_TO_CHECK = 2'b01,
      MSI_TO_READY = 2'b10,
      MSI_TO_FAIL  = 2'b11
   } msi_to_state_t;

   typedef struct packed {
      logic serial_valid;
      logic pulse_valid;
      logic analog_valid;
   } msi_cmd_valid_t;

   typedef struct packed {
      logic brake_output_one;
      logic brake_output_two;
      logic contactor_output;
   } msi_dout_t;

endpackage

// ---- msi_sync2.sv ----
// Two-stage synchroniser for a vector of levels.
// Assumes inputs may change at any time relative to clk.
`timescale 1ns/1ps
module msi_sync2 import msi_pkg::*; #(
   parameter int unsigned W = 1
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         sys_rst,
   // Levels
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;

   initial begin
      if (W < 1) $error("msi_sync2: W must be at least 1");
   end

   // The first stage feeds only the second stage.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule

// ---- msi_blink.sv ----
// Free-running toggle for the status indicator.
// Assumes one clock; HALF is the half period in cycles.
`timescale 1ns/1ps
module msi_blink import msi_pkg::*; #(
   parameter int unsigned HALF = BLINK_HALF_CYC
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic sys_rst,
   // Indicator
   output logic      blink
);
   logic [31:0] cnt_r;

   initial begin
      if (HALF < 1) $error("msi_blink: HALF must be at least 1");
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cnt_r <= 32'h0000_0000;
         blink <= 1'b0;
      end else if (cnt_r >= HALF - 1) begin
         cnt_r <= 32'h0000_0000;
         blink <= ~blink;
      end else begin
         cnt_r <= cnt_r + 32'h0000_0001;
      end
   end
endmodule

// ---- msi_interlock.sv ----
// Safety interlock: command arbitration, torque-off gating with self-check,
// contactor supervision, indicators and a small register port.
// Assumes synchronous inputs except torque-off and command-valid flags.
`timescale 1ns/1ps
module msi_interlock import msi_pkg::*; #(
   parameter int unsigned FAULT_CYC = FAULT_CYCLES,
   parameter int unsigned HALF_CYC  = BLINK_HALF_CYC,
   parameter int unsigned CHK_CYC   = SELFCHK_CYCLES
) (
   // Clock and reset
   input  wire logic           clk,
   input  wire logic           sys_rst,
   // Register port
   input  wire logic [3:0]     reg_addr,
   input  wire logic [7:0]     reg_wdata,
   input  wire logic           reg_wr,
   input  wire logic           reg_rd,
   output logic      [7:0]     reg_rdata,
   output logic                irq,
   // Command sources
   input  wire msi_cmd_valid_t cmd_valid,
   input  wire logic [12:0]    analog_input_one_mv,
   input  wire logic           analog_centered,
   // Torque-off and straps
   input  wire logic           general_input_three,
   input  wire logic           general_input_four,
   input  wire logic           strap_removed,
   input  wire logic           variant_capable,
   input  wire logic           selfchk_ok,
   // Measurements and links
   input  wire logic [15:0]    battery_current_ma,
   input  wire logic           usb_attached,
   // Outputs
   output msi_src_t            active_src,
   output logic                power_enable,
   output logic                motor_start_ok,
   output logic                can_enable,
   output msi_dout_t           dout,
   output logic                power_led,
   output logic                status_led,
   output logic                selfchk_pulse
);

   initial begin
      if (CHK_CYC < 1 || CHK_CYC > 65536 || FAULT_CYC < 1 || HALF_CYC < 1) begin
         $error("msi_interlock: counts out of range");
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Input synchronisation.

   logic [4:0]     sync_q;
   msi_cmd_valid_t cv_s;
   logic           gi3_s;
   logic           gi4_s;

   msi_sync2 #(.W(5)) u_sync (
      .clk     (clk),
      .sys_rst (sys_rst),
      .d       ({cmd_valid, general_input_three, general_input_four}),
      .q       (sync_q)
   );
   assign cv_s  = msi_cmd_valid_t'(sync_q[4:2]);
   assign gi3_s = sync_q[1];
   assign gi4_s = sync_q[0];

   ////////////////////////////////////////////////////////////////////////////////
   // Registers.

   logic [7:0]      ctrl_r;
   logic [EV_W-1:0] irq_st_r;
   logic [EV_W-1:0] irq_mk_r;
   logic [EV_W-1:0] ev;
   msi_to_state_t   to_st_r;
   logic            fault_r;
   logic            to_active;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl_r <= CTRL_RESET;
      end else if (reg_wr && reg_addr == REG_CTRL) begin
         ctrl_r <= reg_wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         irq_mk_r <= '0;
      end else if (reg_wr && reg_addr == REG_IRQ_MK) begin
         irq_mk_r <= reg_wdata[EV_W-1:0];
      end
   end

   // Set wins over a write-one-to-clear in the same cycle.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         irq_st_r <= '0;
      end else if (reg_wr && reg_addr == REG_IRQ_ST) begin
         irq_st_r <= (irq_st_r & ~reg_wdata[EV_W-1:0]) | ev;
      end else begin
         irq_st_r <= irq_st_r | ev;
      end
   end

   assign irq = |(irq_st_r & irq_mk_r);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         unique case (reg_addr)
            REG_CTRL:   reg_rdata <= ctrl_r;
            REG_STATUS: reg_rdata <= {1'b0, fault_r, to_active, to_st_r, power_enable,
                                      active_src};
            REG_IRQ_ST: reg_rdata <= {{(8-EV_W){1'b0}}, irq_st_r};
            REG_IRQ_MK: reg_rdata <= {{(8-EV_W){1'b0}}, irq_mk_r};
            default:    reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Command arbitration.

   logic     ana_in_arb;
   logic     ana_window;
   msi_src_t src_nxt;

   // Analog only joins once software places it in slot two or three.
   assign ana_in_arb = ctrl_r[CTRL_ANA_EN];
   assign ana_window = (analog_input_one_mv >= 13'(ANA_MIN_MV)) &&
                       (analog_input_one_mv <= 13'(ANA_MAX_MV));

   // Slot bit clear puts analog second, ahead of pulse; set puts it third.
   always_comb begin
      src_nxt = MSI_SRC_NONE;
      if (cv_s.serial_valid) begin
         src_nxt = MSI_SRC_SERIAL;
      end else if (ana_in_arb && !ctrl_r[CTRL_ANA_SLOT] && cv_s.analog_valid) begin
         src_nxt = MSI_SRC_ANALOG;
      end else if (cv_s.pulse_valid) begin
         src_nxt = MSI_SRC_PULSE;
      end else if (ana_in_arb && cv_s.analog_valid) begin
         src_nxt = MSI_SRC_ANALOG;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         active_src <= MSI_SRC_NONE;
      end else begin
         active_src <= src_nxt;
      end
   end

   // Start is refused on analog unless centered and within the safe window.
   assign motor_start_ok = ctrl_r[CTRL_RUN_REQ] && (active_src != MSI_SRC_NONE) &&
                           ((active_src != MSI_SRC_ANALOG) ||
                            (analog_centered && ana_window));

   ////////////////////////////////////////////////////////////////////////////////
   // Torque-off with self-check.

   logic both_high;
   logic both_high_d_r;
   logic [15:0] chk_cnt_r;

   // The straps are plain levels; torque-off follows them without a restart.
   assign to_active = strap_removed && variant_capable;
   // When active, inputs three and four become the two torque-off channels.
   assign both_high = to_active && gi3_s && gi4_s;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         both_high_d_r <= 1'b0;
      end else begin
         both_high_d_r <= both_high;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         to_st_r   <= MSI_TO_OFF;
         chk_cnt_r <= 16'h0000;
      end else begin
         unique case (to_st_r)
            MSI_TO_OFF: begin
               // Power-on runs a check as soon as inputs first read both high.
               if (both_high && !both_high_d_r) begin
                  to_st_r   <= MSI_TO_CHECK;
                  chk_cnt_r <= 16'h0000;
               end
            end
            MSI_TO_CHECK: begin
               if (!both_high) begin
                  to_st_r <= MSI_TO_OFF;
               end else if (chk_cnt_r >= 16'(CHK_CYC - 1)) begin
                  to_st_r <= selfchk_ok ? MSI_TO_READY : MSI_TO_FAIL;
               end else begin
                  chk_cnt_r <= chk_cnt_r + 16'h0001;
               end
            end
            MSI_TO_READY: begin
               if (!both_high) to_st_r <= MSI_TO_OFF;
            end
            MSI_TO_FAIL: begin
               if (!both_high) to_st_r <= MSI_TO_OFF;
            end
         endcase
      end
   end

   assign selfchk_pulse = (to_st_r == MSI_TO_CHECK);

   // Both inputs high and check passed; either low drops drive at once.
   // Removing drive stops switching and clears both brake outputs on the next clock.
   assign power_enable = !fault_r && (!to_active ||
                         (both_high && to_st_r == MSI_TO_READY));

   ////////////////////////////////////////////////////////////////////////////////
   // Contactor supervision.

   logic [31:0] flt_cnt_r;
   logic        over_cur;

   assign over_cur = battery_current_ma >= 16'(CUR_LIMIT_MA);

   // A stuck power switch draws current even when drive should be off.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         flt_cnt_r <= 32'h0000_0000;
         fault_r   <= 1'b0;
      end else if (!power_enable && over_cur && !fault_r) begin
         if (flt_cnt_r >= 32'(FAULT_CYC)) begin
            fault_r <= 1'b1;
         end else begin
            flt_cnt_r <= flt_cnt_r + 32'h0000_0001;
         end
      end else if (!fault_r) begin
         flt_cnt_r <= 32'h0000_0000;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         dout <= '0;
      end else begin
         dout.brake_output_one <= ctrl_r[CTRL_BRAKE1] && power_enable;
         dout.brake_output_two <= ctrl_r[CTRL_BRAKE2] && power_enable;
         dout.contactor_output <= ctrl_r[CTRL_CONTACT] && !fault_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Events, indicators and links.

   msi_src_t src_d_r;
   logic     blink;
   logic     pe_d_r;
   logic     fault_d_r;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         src_d_r   <= MSI_SRC_NONE;
         pe_d_r    <= 1'b0;
         fault_d_r <= 1'b0;
      end else begin
         src_d_r   <= active_src;
         pe_d_r    <= power_enable;
         fault_d_r <= fault_r;
      end
   end

   // Events last one cycle, so a write-one-to-clear sticks once the cause is reported.
   assign ev[EV_FAULT]      = fault_r && !fault_d_r;
   assign ev[EV_TORQUE_OFF] = pe_d_r && !power_enable;
   assign ev[EV_CHK_FAIL]   = (to_st_r == MSI_TO_CHECK) && both_high && !selfchk_ok &&
                              (chk_cnt_r >= 16'(CHK_CYC - 1));
   assign ev[EV_SRC_CHG]    = (src_d_r != active_src);

   msi_blink #(.HALF(HALF_CYC)) u_blink (
      .clk     (clk),
      .sys_rst (sys_rst),
      .blink   (blink)
   );

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         power_led  <= 1'b0;
         status_led <= 1'b0;
      end else begin
         power_led  <= 1'b1;
         status_led <= fault_r ? 1'b1 : blink;
      end
   end

   // CAN stays up regardless of the USB attach state.
   assign can_enable = 1'b1 | usb_attached;

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions.

   sva_src_prio_a: assert property (@(posedge clk) disable iff (sys_rst)
      cv_s.serial_valid |=> active_src == MSI_SRC_SERIAL)
      else $error("serial source not chosen");
   sva_ana_excl_a: assert property (@(posedge clk) disable iff (sys_rst)
      !ctrl_r[CTRL_ANA_EN] |=> active_src != MSI_SRC_ANALOG)
      else $error("analog chosen while excluded");
   sva_ana_start_a: assert property (@(posedge clk) disable iff (sys_rst)
      (active_src == MSI_SRC_ANALOG && !ana_window) |-> !motor_start_ok)
      else $error("start allowed outside analog window");
   sva_both_high_a: assert property (@(posedge clk) disable iff (sys_rst)
      (to_active && power_enable) |-> (gi3_s && gi4_s))
      else $error("drive with a torque-off input low");
   sva_chk_first_a: assert property (@(posedge clk) disable iff (sys_rst)
      (to_active && $rose(both_high)) |-> ##1 !power_enable)
      else $error("drive before self-check");
   sva_one_low_a: assert property (@(posedge clk) disable iff (sys_rst)
      (to_active && !gi4_s) |-> !power_enable)
      else $error("drive with input four low");
   sva_default_off_a: assert property (@(posedge clk) disable iff (sys_rst)
      !variant_capable |-> (!fault_r |-> power_enable))
      else $error("torque-off acted on incapable variant");
   sva_contact_a: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(fault_r) |=> !dout.contactor_output)
      else $error("contactor held after fault");
   sva_fault_time_a: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(fault_r) |-> $past(flt_cnt_r) >= 32'(FAULT_CYC))
      else $error("fault declared too early");
   sva_power_led_a: assert property (@(posedge clk) disable iff (sys_rst)
      !$past(sys_rst) |-> power_led)
      else $error("power indicator dark");

   cov_pulse_c: cover property (@(posedge clk) disable iff (sys_rst)
      active_src == MSI_SRC_PULSE);
   cov_ready_c: cover property (@(posedge clk) disable iff (sys_rst)
      to_st_r == MSI_TO_CHECK ##1 to_st_r == MSI_TO_READY);
   cov_fault_c: cover property (@(posedge clk) disable iff (sys_rst) $rose(fault_r));
   cov_analog_c: cover property (@(posedge clk) disable iff (sys_rst)
      active_src == MSI_SRC_ANALOG && motor_start_ok);
   cov_chk_fail_c: cover property (@(posedge clk) disable iff (sys_rst) to_st_r == MSI_TO_FAIL);

endmodule

// ---- msi_far_side.sv ----
// Behavioural model of the parties outside the interlock: torque-off switches,
// command sources, self-check circuit and the power stage that draws battery current.
// Assumes the bench sets the request inputs; pins change right after a rising edge.
`timescale 1ns/1ps
module msi_far_side import msi_pkg::*; (
   // Clock
   input  wire logic           clk,
   // Scenario requests
   input  wire logic [1:0]     want_to,
   input  wire logic [2:0]     want_src,
   input  wire logic           want_chk,
   input  wire logic           stage_bad,
   input  wire logic [15:0]    load_ma,
   // Observed drive state
   input  wire logic           power_enable,
   // Pins toward the interlock
   output logic                to_a,
   output logic                to_b,
   output msi_cmd_valid_t      cmd_valid,
   output logic                selfchk_ok,
   output logic [15:0]         battery_current_ma
);
   ////////////////////////////////////////////////////////////////////////////
   // Torque is permitted only by holding both channels high together.
   always @(posedge clk) begin
      to_a <= want_to[1];
      to_b <= want_to[0];
      cmd_valid <= want_src;
      selfchk_ok <= want_chk;
   end
   ////////////////////////////////////////////////////////////////////////////
   // A healthy stage draws current only while driven; a failed one leaks anyway.
   always @(posedge clk) begin
      battery_current_ma <= (stage_bad || power_enable) ? load_ma : 16'h0000;
   end
endmodule

// ---- msi_interlock_test.sv ----
// Self-checking bench for the motor safety interlock with shortened counts.
// Assumes msi_far_side stands for everything outside the block.
`timescale 1ns/1ps
module msi_interlock_test import msi_pkg::*;;
   localparam int unsigned FC = 20;
   localparam int unsigned HC = 4;
   localparam int unsigned CC = 3;
   logic clk, sys_rst, reg_wr, reg_rd, rd_d, centered, strap, variant, usb;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata;
   logic [12:0] ana_mv;
   logic [1:0] want_to;
   logic [2:0] want_src;
   logic want_chk, stage_bad, irq, power_enable, motor_start_ok, can_enable;
   logic power_led, status_led, selfchk_pulse, to_a, to_b, selfchk_ok;
   logic [15:0] load_ma, cur_ma;
   msi_cmd_valid_t cmd_valid;
   msi_src_t active_src;
   msi_dout_t dout;
   logic [7:0] exp_q[$];
   int error_cnt, n_tests, seed, n, i;
   msi_interlock #(.FAULT_CYC(FC), .HALF_CYC(HC), .CHK_CYC(CC)) DUT (
      .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
      .cmd_valid(cmd_valid), .analog_input_one_mv(ana_mv), .analog_centered(centered),
      .general_input_three(to_a), .general_input_four(to_b), .strap_removed(strap),
      .variant_capable(variant), .selfchk_ok(selfchk_ok), .battery_current_ma(cur_ma),
      .usb_attached(usb), .active_src(active_src), .power_enable(power_enable),
      .motor_start_ok(motor_start_ok), .can_enable(can_enable), .dout(dout),
      .power_led(power_led), .status_led(status_led), .selfchk_pulse(selfchk_pulse));
   msi_far_side FAR (
      .clk(clk), .want_to(want_to), .want_src(want_src), .want_chk(want_chk),
      .stage_bad(stage_bad), .load_ma(load_ma), .power_enable(power_enable),
      .to_a(to_a), .to_b(to_b), .cmd_valid(cmd_valid), .selfchk_ok(selfchk_ok),
      .battery_current_ma(cur_ma));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      $display("Counts: %0d compares, %0d mismatches", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH at %0t: %s got %h expected %h", $time, m, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      exp_q.push_back(e);
      @(posedge clk);
      reg_rd <= 1'b0;
   endtask
   // Returns the cycles taken for power_enable to reach v, or -1 after lim cycles.
   task automatic wait_pe(input logic v, input int lim, output int c, output logic saw);
      c = -1;
      saw = 1'b0;
      for (int k = 0; k < lim && c < 0; k++) begin
         @(negedge clk);
         saw = saw | (selfchk_pulse === 1'b1);
         if (power_enable === v) c = k;
      end
      @(posedge clk);
   endtask
   function automatic msi_src_t exp_src(logic [2:0] v, logic en, logic slot);
      if (v[2]) return MSI_SRC_SERIAL;
      if (en && !slot && v[0]) return MSI_SRC_ANALOG;
      if (v[1]) return MSI_SRC_PULSE;
      if (en && v[0]) return MSI_SRC_ANALOG;
      return MSI_SRC_NONE;
   endfunction
   ////////////////////////////////////////////////////////////////////////////
   // Read data stand only in the cycle after the strobe, so sample exactly there.
   always @(posedge clk) begin
      rd_d <= reg_rd;
      if (rd_d === 1'b1) begin
         if (exp_q.size() == 0) chk(1, 0, "read without a note");
         else chk(reg_rdata, exp_q.pop_front(), "register read");
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin : main
      logic saw;
      logic [7:0] ctl;
      logic [12:0] mv_tab[5];
      error_cnt = 0;
      n_tests = 0;
      seed = 15;
      sys_rst = 1'b1;
      {reg_wr, reg_rd, centered, strap, variant, usb} = '0;
      {reg_addr, reg_wdata, ana_mv, want_to, want_src} = '0;
      {want_chk, stage_bad, load_ma} = '0;
      mv_tab = '{13'h00F9, 13'h128F, 13'h09C4, 13'h00FA, 13'h128E};
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      rd(REG_CTRL, CTRL_RESET);
      rd(REG_IRQ_MK, 8'h00);
      rd(4'h7, 8'h00);
      chk(power_led, 1, "power indicator");
      usb <= 1'b1;
      repeat (3) @(posedge clk);
      chk(can_enable, 1, "link kept with usb");
      n = 0;
      @(negedge clk);
      saw = status_led;
      for (i = 0; i < 8 * HC; i++) begin
         @(negedge clk);
         if (status_led !== saw) n++;
         saw = status_led;
      end
      chk(n, 8, "blink toggle count");
      @(posedge clk);
      strap <= 1'b1;
      repeat (4) @(posedge clk);
      chk(power_enable, 1, "torque-off off on plain variant");
      $display("Test reset and indicators done");
      for (i = 0; i < 24; i++) begin
         if (i % 8 == 0) wr(REG_CTRL, (i / 8 == 0) ? 8'h00 : (i / 8 == 1) ? 8'h01 : 8'h03);
         want_src <= 3'($random(seed));
         repeat (5) @(posedge clk);
         chk(active_src, exp_src(want_src, i >= 8, i >= 16), "source");
      end
      $display("Test arbitration done");
      wr(REG_CTRL, 8'h07);
      want_src <= 3'b001;
      repeat (5) @(posedge clk);
      for (i = 0; i < 5; i++) begin
         ana_mv <= mv_tab[i];
         centered <= (i != 2);
         repeat (2) @(posedge clk);
         chk(motor_start_ok, i >= 3, "analog start window");
      end
      want_src <= 3'b000;
      wr(REG_CTRL, 8'h00);
      $display("Test analog start done");
      variant <= 1'b1;
      repeat (5) @(posedge clk);
      chk(power_enable, 0, "both channels low");
      want_chk <= 1'b1;
      for (i = 0; i < 2; i++) begin
         want_to <= 2'b11;
         wait_pe(1, 20, n, saw);
         chk(n >= CC && saw, 1, "drive after self-check");
         want_to <= i ? 2'b10 : 2'b01;
         repeat (4) @(posedge clk);
         chk(power_enable, 0, "one channel low");
      end
      want_chk <= 1'b0;
      want_to <= 2'b11;
      wait_pe(1, CC + 12, n, saw);
      chk(n, -1, "failed check keeps drive off");
      want_to <= 2'b00;
      want_chk <= 1'b1;
      repeat (4) @(posedge clk);
      want_to <= 2'b11;
      wait_pe(1, 20, n, saw);
      chk(n >= CC && saw, 1, "check reruns after failure");
      $display("Test torque-off done");
      ctl = 8'h00;
      ctl[CTRL_CONTACT] = 1'b1;
      ctl[CTRL_BRAKE1] = 1'b1;
      ctl[CTRL_BRAKE2] = 1'b1;
      wr(REG_CTRL, ctl);
      repeat (2) @(posedge clk);
      chk(dout, 3'b111, "default outputs");
      want_to <= 2'b00;
      repeat (5) @(posedge clk);
      chk(dout, 3'b001, "brakes held without drive");
      wr(REG_IRQ_ST, 8'hFF);
      wr(REG_IRQ_MK, 8'h01);
      stage_bad <= 1'b1;
      load_ma <= 16'd1500;
      repeat (FC - 5) @(posedge clk);
      load_ma <= 16'd999;
      @(posedge clk);
      load_ma <= 16'd1500;
      repeat (FC - 5) @(posedge clk);
      chk({dout.contactor_output, irq}, 2'b10, "short over-current kept");
      load_ma <= 16'd1000;
      repeat (FC + 6) @(posedge clk);
      chk({dout.contactor_output, irq}, 2'b01, "stage failure drops coil");
      chk(status_led, 1, "fault lights status steadily");
      rd(REG_IRQ_ST, 8'h01);
      rd(REG_STATUS, 8'h60);
      wr(REG_IRQ_ST, 8'h01);
      repeat (2) @(posedge clk);
      chk(irq, 0, "event cleared");
      $display("Test contactor supervision done");
      stage_bad <= 1'b0;
      want_to <= 2'b11;
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      wait_pe(1, 20, n, saw);
      chk(n >= CC && saw, 1, "check after restart");
      $display("Test restart self-check done");
      repeat (3) @(posedge clk);
      give_verdict();
   end
   initial begin
      #100000;
      error_cnt++;
      $display("MISMATCH at %0t: run limit reached", $time);
      give_verdict();
   end
endmodule
